/* bench/dma_far_side.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Peripheral and RAM read side of the engine
module dma_far_side (
   input  wire logic        clk,
   input  wire logic [15:0] ramAddr,
   input  wire logic        ramRead,
   input  wire logic [15:0] periphAddr,
   input  wire logic        periphRead,
   output logic      [15:0] ramRdata,
   output logic      [15:0] periphRdata
);
   logic ramValid    = 1'b0;
   logic periphValid = 1'b0;
   always @(posedge clk) begin
      ramValid    <= ramRead;
      periphValid <= periphRead;
   end
   // Outside the valid cycle the inverse shows, so a late sample cannot match
   assign ramRdata    = ramValid ? ramAddr ^ 16'h5a5a : ~(ramAddr ^ 16'h5a5a);
   assign periphRdata = periphValid ? periphAddr ^ 16'h5a5a : ~(periphAddr ^ 16'h5a5a);
endmodule : dma_far_side

`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin nMismatch++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module tb;
   logic clk = 0, rstN = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic ramRead, ramWrite, ramByte, periphRead, periphWrite, err;
   logic [7:0] paddr = 0, irq;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [127:0] req = 0;
   logic [15:0] rRd, pRd, ramAddr, ramWdata, periphAddr, periphWdata;
   logic [15:0] pio = 16'h0000;
   logic [16:0] aq[$];
   logic [15:0] dq[$];
   int irqN = 0, nMismatch = 0, cmpCount = 0;

   always #25 clk = ~clk;

   dma_channel_register_control u_dut (.clk(clk), .rst_n(rstN), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'h3), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .periphRequest(req), .periphIndirectOffset(pio),
      .ramAddr(ramAddr), .ramRead(ramRead), .ramWrite(ramWrite), .ramByte(ramByte),
      .ramWdata(ramWdata), .ramRdata(rRd), .periphAddr(periphAddr), .periphRead(periphRead),
      .periphWrite(periphWrite), .periphWdata(periphWdata), .periphRdata(pRd), .blockIrq(irq));
   dma_far_side u_far (.clk(clk), .ramAddr(ramAddr), .ramRead(ramRead), .periphAddr(periphAddr),
      .periphRead(periphRead), .ramRdata(rRd), .periphRdata(pRd));

   always @(posedge clk) begin
      if (ramRead | ramWrite) aq.push_back({ramByte, ramAddr});
      if (ramWrite | periphWrite) dq.push_back(ramWrite ? ramWdata : periphWdata);
      if (ramWrite & periphWrite) dq.push_back(periphWdata);
      if (irq[0]) irqN++;
   end

   task automatic apb(input logic [7:0] a, input logic w, input logic [15:0] d);
      @(posedge clk);
      psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= {16'h0000, d};
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
   endtask : apb

   task automatic conclude;
      $display("mismatches %0d comparisons %0d", nMismatch, cmpCount);
      if (nMismatch == 0 && cmpCount > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude

   // Address, count and buffers only written while the channel is off
   task automatic setup(input logic [15:0] primary_start, stb, cnt, ctrl);
      aq.delete(); dq.delete(); irqN = 0;
      apb(8'h08, 1, primary_start); apb(8'h0c, 1, stb); apb(8'h10, 1, 16'h0040); apb(8'h14, 1, cnt);
      apb(8'h00, 1, ctrl);
   endtask : setup

   task automatic regs_test;
      apb(8'h00, 0, 0); `CHK(rd, 32'h0)
      apb(8'h14, 1, 16'hffff); apb(8'h14, 0, 0); `CHK(rd, 32'h03ff)
      apb(8'h2c, 1, 16'hffff); apb(8'h2c, 0, 0); `CHK(rd, 32'hffff)
      apb(8'h18, 1, 16'h1234); `CHK(err, 1'b1)
   endtask : regs_test

   task automatic force_test;
      setup(16'h0100, 16'h0, 16'h0, 16'h8001);
      apb(8'h04, 1, 16'h8000);
      repeat (12) @(posedge clk);
      `CHK(aq[0], 17'h00100)
      `CHK(dq[0], 16'h5a1a)
      `CHK(irqN, 1)
      apb(8'h04, 0, 0); `CHK(rd, 32'h0)
      apb(8'h00, 0, 0); `CHK(rd, 32'h0001)
   endtask : force_test

   task automatic pingpong_test;
      setup(16'h0200, 16'h0300, 16'h1, 16'h8003);
      apb(8'h04, 1, 16'h0005);
      repeat (5) begin
         @(posedge clk) req <= 128'h1 << 5;
         @(posedge clk) req <= 0;
         repeat (8) @(posedge clk);
      end
      `CHK({aq[0], aq[1], aq[2], aq[3]}, {17'h0200, 17'h0202, 17'h0300, 17'h0302})
      `CHK(aq.size(), 4)
      `CHK(irqN, 2)
   endtask : pingpong_test

   task automatic fixed_byte_test;
      setup(16'h0400, 16'h0, 16'h3, 16'hf011);
      apb(8'h04, 1, 16'h0006);
      repeat (4) begin
         @(posedge clk) req <= 128'h1 << 6;
         @(posedge clk) req <= 0;
         repeat (8) @(posedge clk);
      end
      foreach (aq[i]) `CHK(aq[i], 17'h10400)
      foreach (dq[i]) `CHK(dq[i], 16'h5e5a)
      `CHK(dq.size(), 4)
      `CHK(irqN, 1)
      apb(8'h00, 0, 0); `CHK(rd, 32'h7011)
   endtask : fixed_byte_test

   task automatic pulses(input int n, input int line);
      repeat (n) begin
         @(posedge clk) req <= 128'h1 << line;
         @(posedge clk) req <= 0;
         repeat (8) @(posedge clk);
      end
   endtask : pulses

   // Continuous ping-pong with null write and peripheral indirect, then plain continuous
   task automatic cont_test;
      pio <= 16'h0010;
      setup(16'h0500, 16'h0600, 16'h0, 16'h8822);
      apb(8'h04, 1, 16'h0007);
      pulses(3, 7);
      `CHK({aq[0], aq[1], aq[2]}, {17'h0510, 17'h0610, 17'h0510})
      `CHK({dq[0], dq[1], dq[3]}, {16'h5a1a, 16'h0000, 16'h0000})
      `CHK(irqN, 3)
      apb(8'h00, 1, 16'h0000);
      setup(16'h0700, 16'h0, 16'h1, 16'h8000);
      pulses(3, 7);
      `CHK({aq[0], aq[1], aq[2]}, {17'h0700, 17'h0702, 17'h0700})
      `CHK(irqN, 1)
   endtask : cont_test

   initial begin
      repeat (8) @(posedge clk);
      rstN <= 1;
      regs_test();
      force_test();
      pingpong_test();
      fixed_byte_test();
      cont_test();
      conclude();
   end

   // Whole sequence needs about 290 cycles
   initial begin
      repeat (3000) @(posedge clk);
      nMismatch++;
      conclude();
   end
endmodule : tb

`default_nettype wire

/* include/dma_channel_pkg.sv */
// Operation
// R1: Eight channels, six 16-bit registers each
// R2: Channel runs only while enable bit set
// R3: Size bit: one selects byte, zero word
// R4: Direction bit: one RAM to peripheral
// R5: Half bit raises interrupt at half block
// R6: Null write adds zero peripheral write
// R7: Addressing mode field selects RAM addressing
// R8: Post-increment advances, otherwise address stays fixed
// R9: Mode 11: one block per buffer, stop
// R10: Mode 10: continuous alternating ping-pong buffers
// R11: Mode 01 one-shot, 00 continuous primary
// R12: Force bit starts one manual transfer
// R13: Force bit cleared only by hardware
// R14: Without force, peripheral request starts transfer
// R15: Seven-bit field picks one request line
// R16: Primary offset is first RAM start
// R17: Secondary offset is alternate RAM start
// R18: Peripheral address register targets every transfer
// R19: Software avoids writing address, count while enabled
// R20: Block length is count field plus one
// R21: Unimplemented bits read zero, ignore writes
// R22: Channel interrupt at block end or half
// R23: One-shot stops after its final block
// R24: Continuous mode reloads start address each block
// R25: Ping-pong alternates the two start addresses
// R26: Post-increment step one byte, two word
// R27: Final one-shot block clears enable bit
`default_nettype none

package dma_channel_pkg;

   // ===========================================================
   // Sizes
   localparam int NUM_CHANNELS = 8;
   localparam int DATA_W       = 16;
   localparam int COUNT_W      = 10;
   localparam int REQ_SEL_W    = 7;
   localparam int NUM_REQ      = 128;
   localparam int APB_ADDR_W   = 8;

   // ===========================================================
   // Address map: channel in bits 7:5, register index in bits 4:2
   localparam int REG_LSB = 2;
   localparam int REG_MSB = 4;
   localparam int CH_LSB  = 5;
   localparam int CH_MSB  = 7;

   localparam logic [2:0] IDX_CONTROL   = 3'h0;
   localparam logic [2:0] IDX_REQUEST   = 3'h1;
   localparam logic [2:0] IDX_PRIMARY   = 3'h2;
   localparam logic [2:0] IDX_SECONDARY = 3'h3;
   localparam logic [2:0] IDX_PERIPH    = 3'h4;
   localparam logic [2:0] IDX_COUNT     = 3'h5;

   // ===========================================================
   // Field positions
   localparam int CTRL_ENABLE_BIT = 15;
   localparam int CTRL_SIZE_BIT   = 14;
   localparam int CTRL_DIR_BIT    = 13;
   localparam int CTRL_HALF_BIT   = 12;
   localparam int CTRL_NULL_PERIPHERAL_WRITE_BIT  = 11;
   localparam int CTRL_ADDRESSING_MODE_LSB  = 4;
   localparam int CTRL_MODE_LSB   = 0;
   localparam int REQ_FORCE_BIT   = 15;

   // Implemented-bit masks
   localparam logic [15:0] CONTROL_MASK = 16'hf833;
   localparam logic [15:0] REQUEST_MASK = 16'h807f;
   localparam logic [15:0] COUNT_MASK   = 16'h03ff;
   localparam logic [15:0] FULL_MASK    = 16'hffff;
   localparam logic [15:0] RESET_VALUE  = 16'h0000;

   // ===========================================================
   // Modes
   localparam logic [1:0] ADDRESSING_MODE_POSTINC = 2'h0;
   localparam logic [1:0] ADDRESSING_MODE_FIXED   = 2'h1;
   localparam logic [1:0] ADDRESSING_MODE_PERIPH  = 2'h2;

   localparam logic [1:0] OPMODE_CONT       = 2'h0;
   localparam logic [1:0] OPMODE_ONESHOT    = 2'h1;
   localparam logic [1:0] OPMODE_CONT_PP    = 2'h2;
   localparam logic [1:0] OPMODE_ONESHOT_PP = 2'h3;

   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;

   typedef enum logic [1:0] {
      ENG_IDLE,
      ENG_READ,
      ENG_CAPTURE,
      ENG_WRITE
   } engine_state_type;

endpackage : dma_channel_pkg

`default_nettype wire

/* rtl/dma_channel_register_control.sv */
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module dma_channel_register_control #(
   parameter int NCH   = dma_channel_pkg::NUM_CHANNELS,
   parameter int NREQ  = dma_channel_pkg::NUM_REQ
) (
   input  wire logic                                  clk,
   input  wire logic                                  rst_n,
   input  wire logic [dma_channel_pkg::APB_ADDR_W-1:0] paddr,
   input  wire logic                                  psel,
   input  wire logic                                  penable,
   input  wire logic                                  pwrite,
   input  wire logic [31:0]                           pwdata,
   input  wire logic [3:0]                            pstrb,
   output var  logic [31:0]                           prdata,
   output      logic                                  pready,
   output var  logic                                  pslverr,
   input  wire logic [NREQ-1:0]                       periphRequest,
   input  wire logic [15:0]                           periphIndirectOffset,
   output var  logic [15:0]                           ramAddr,
   output var  logic                                  ramRead,
   output var  logic                                  ramWrite,
   output var  logic                                  ramByte,
   output var  logic [15:0]                           ramWdata,
   input  wire logic [15:0]                           ramRdata,
   output var  logic [15:0]                           periphAddr,
   output var  logic                                  periphRead,
   output var  logic                                  periphWrite,
   output var  logic [15:0]                           periphWdata,
   input  wire logic [15:0]                           periphRdata,
   output var  logic [NCH-1:0]                        blockIrq
);

   localparam int CHW = $clog2(NCH);

   // ===========================================================
   // Channel registers and per-channel engine state
   logic [15:0]        control        [NCH]; // R1
   logic [15:0]        requestSel     [NCH];
   logic [15:0]        primaryStart   [NCH];
   logic [15:0]        secondaryStart [NCH];
   logic [15:0]        periphTarget   [NCH];
   logic [15:0]        countReg       [NCH];
   logic [15:0]        ramPtr         [NCH];
   logic [9:0]         xferIdx        [NCH];
   logic [NCH-1:0]     pingSel;
   logic [NCH-1:0]     pending;
   logic [NCH-1:0]     forceTaken;

   dma_channel_pkg::engine_state_type state;
   logic [CHW-1:0]     curCh;
   logic               curForced;
   logic               curDir;
   logic               curNull;

   // ===========================================================
   // APB slave
   wire              setupPhase  = psel & ~penable;
   wire              accessPhase = psel & penable;
   wire [2:0]        regIdx      = paddr[dma_channel_pkg::REG_MSB:dma_channel_pkg::REG_LSB];
   wire [CHW-1:0]    chIdx       = paddr[dma_channel_pkg::CH_MSB:dma_channel_pkg::CH_LSB];
   wire              addrValid   = (regIdx <= dma_channel_pkg::IDX_COUNT)
                                   && (paddr[1:0] == 2'h0);
   wire              writeEn     = accessPhase & pwrite & addrValid;
   wire [15:0]       laneMask    = {{8{pstrb[1]}}, {8{pstrb[0]}}};
   wire [15:0]       wrData      = pwdata[15:0];

   // Byte-lane merge that also drops writes to unimplemented bits
   function automatic logic [15:0] mergeWrite(input logic [15:0] old,
                                              input logic [15:0] data,
                                              input logic [15:0] lanes,
                                              input logic [15:0] impl);
      mergeWrite = ((old & ~lanes) | (data & lanes)) & impl;
   endfunction : mergeWrite

   // Lowest-numbered channel wins; fixed priority keeps the arbiter tiny
   function automatic logic [CHW-1:0] pickLowest(input logic [NCH-1:0] vec);
      pickLowest = '0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (vec[i]) begin
            pickLowest = CHW'(i);
         end
      end
   endfunction : pickLowest

   wire [15:0] readWord =
      (regIdx == dma_channel_pkg::IDX_CONTROL)   ? control[chIdx]        :
      (regIdx == dma_channel_pkg::IDX_REQUEST)   ? requestSel[chIdx]     :
      (regIdx == dma_channel_pkg::IDX_PRIMARY)   ? primaryStart[chIdx]   :
      (regIdx == dma_channel_pkg::IDX_SECONDARY) ? secondaryStart[chIdx] :
      (regIdx == dma_channel_pkg::IDX_PERIPH)    ? periphTarget[chIdx]   :
      (regIdx == dma_channel_pkg::IDX_COUNT)     ? countReg[chIdx]       :
      16'h0000;

   assign pready = 1'b1;

   // Read data is sampled in the setup cycle so prdata comes from a flop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setupPhase) begin
         prdata  <= {16'h0000, readWord}; // R21
         pslverr <= ~addrValid;
      end
   end

   // ===========================================================
   // Arbitration
   logic [NCH-1:0] enableVec;
   logic [NCH-1:0] forceReq;
   logic [NCH-1:0] eligible;
   logic [NCH-1:0] xferDone;
   logic [NCH-1:0] forceSet;
   logic [NCH-1:0] lastBlk;
   logic [NCH-1:0] halfPoint;
   logic [15:0]    stepVec [NCH];

   wire            anyEligible = |eligible;
   wire [CHW-1:0]  grantCh     = pickLowest(eligible);
   wire            grantNow    = (state == dma_channel_pkg::ENG_IDLE) && anyEligible;
   wire [15:0]     grantCtl    = control[grantCh];
   wire [1:0]      grantAmode  = grantCtl[dma_channel_pkg::CTRL_ADDRESSING_MODE_LSB +: 2];
   wire [15:0]     grantBase   = pingSel[grantCh] ? secondaryStart[grantCh]
                                                  : primaryStart[grantCh];
   wire [15:0]     grantRam    = (grantAmode == dma_channel_pkg::ADDRESSING_MODE_PERIPH)
                                 ? 16'(grantBase + periphIndirectOffset)
                                 : ramPtr[grantCh]; // R7

   // ===========================================================
   // Per-channel register file and block bookkeeping
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      wire        hit      = writeEn && (chIdx == CHW'(c));
      wire        hitCtl   = hit && (regIdx == dma_channel_pkg::IDX_CONTROL);
      wire        hitReq   = hit && (regIdx == dma_channel_pkg::IDX_REQUEST);
      wire        enabled  = control[c][dma_channel_pkg::CTRL_ENABLE_BIT];
      wire [1:0]  addressing_mode    = control[c][dma_channel_pkg::CTRL_ADDRESSING_MODE_LSB +: 2];
      wire [1:0]  opMode   = control[c][dma_channel_pkg::CTRL_MODE_LSB +: 2];
      wire        granted  = grantNow && (grantCh == CHW'(c));
      wire        reqLine  = periphRequest[requestSel[c][dma_channel_pkg::REQ_SEL_W-1:0]]; // R15
      wire        forceDone = xferDone[c] && curForced;

      assign enableVec[c] = enabled;
      assign forceReq[c]  = requestSel[c][dma_channel_pkg::REQ_FORCE_BIT] & ~forceTaken[c];
      assign eligible[c]  = enabled & (pending[c] | forceReq[c]); // R2 R14
      assign xferDone[c]  = (state == dma_channel_pkg::ENG_WRITE) && (curCh == CHW'(c));
      assign forceSet[c]  = hitReq && pstrb[1] && wrData[dma_channel_pkg::REQ_FORCE_BIT];
      assign lastBlk[c]   = xferIdx[c] == countReg[c][dma_channel_pkg::COUNT_W-1:0]; // R20
      assign halfPoint[c] = xferIdx[c] == {1'b0, countReg[c][dma_channel_pkg::COUNT_W-1:1]};
      assign stepVec[c]   = control[c][dma_channel_pkg::CTRL_SIZE_BIT]
                            ? dma_channel_pkg::STEP_BYTE : dma_channel_pkg::STEP_WORD; // R26

      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            control[c]        <= dma_channel_pkg::RESET_VALUE; // R2
            requestSel[c]     <= dma_channel_pkg::RESET_VALUE;
            primaryStart[c]   <= dma_channel_pkg::RESET_VALUE;
            secondaryStart[c] <= dma_channel_pkg::RESET_VALUE;
            periphTarget[c]   <= dma_channel_pkg::RESET_VALUE;
            countReg[c]       <= dma_channel_pkg::RESET_VALUE;
            ramPtr[c]         <= dma_channel_pkg::RESET_VALUE;
            xferIdx[c]        <= '0;
            pingSel[c]        <= 1'b0;
            pending[c]        <= 1'b0;
            forceTaken[c]     <= 1'b0;
            blockIrq[c]       <= 1'b0;
         end else begin
            if (hitCtl) begin
               control[c] <= mergeWrite(control[c], wrData, laneMask,
                                        dma_channel_pkg::CONTROL_MASK); // R21
            end
            if (hitReq && pstrb[0]) begin
               requestSel[c][dma_channel_pkg::REQ_SEL_W-1:0] <=
                  wrData[dma_channel_pkg::REQ_SEL_W-1:0]; // R15
            end
            // A zero write leaves force alone; a new set beats the clear
            if (forceSet[c]) begin
               requestSel[c][dma_channel_pkg::REQ_FORCE_BIT] <= 1'b1; // R12
            end else if (forceDone) begin
               requestSel[c][dma_channel_pkg::REQ_FORCE_BIT] <= 1'b0; // R13
            end
            if (hit && regIdx == dma_channel_pkg::IDX_PRIMARY) begin
               primaryStart[c] <= mergeWrite(primaryStart[c], wrData, laneMask,
                                             dma_channel_pkg::FULL_MASK); // R16
            end
            if (hit && regIdx == dma_channel_pkg::IDX_SECONDARY) begin
               secondaryStart[c] <= mergeWrite(secondaryStart[c], wrData, laneMask,
                                               dma_channel_pkg::FULL_MASK); // R17
            end
            if (hit && regIdx == dma_channel_pkg::IDX_PERIPH) begin
               periphTarget[c] <= mergeWrite(periphTarget[c], wrData, laneMask,
                                             dma_channel_pkg::FULL_MASK); // R18
            end
            if (hit && regIdx == dma_channel_pkg::IDX_COUNT) begin
               countReg[c] <= mergeWrite(countReg[c], wrData, laneMask,
                                         dma_channel_pkg::COUNT_MASK); // R21
            end

            // Request capture: a new request beats the grant-time clear
            if (enabled && reqLine) begin
               pending[c] <= 1'b1; // R14
            end else if (!enabled || (granted && !forceReq[c])) begin
               pending[c] <= 1'b0;
            end

            if (granted && forceReq[c]) begin
               forceTaken[c] <= 1'b1;
            end else if (forceDone) begin
               forceTaken[c] <= 1'b0;
            end

            blockIrq[c] <= xferDone[c] && (control[c][dma_channel_pkg::CTRL_HALF_BIT]
                           ? halfPoint[c] : lastBlk[c]); // R5 R22

            // Idle channel tracks the primary buffer so enabling starts clean
            if (!enabled) begin
               ramPtr[c]  <= primaryStart[c];
               xferIdx[c] <= '0;
               pingSel[c] <= 1'b0;
            end else if (xferDone[c] && !lastBlk[c]) begin
               xferIdx[c] <= 10'(xferIdx[c] + 10'h001);
               if (addressing_mode == dma_channel_pkg::ADDRESSING_MODE_POSTINC) begin
                  ramPtr[c] <= 16'(ramPtr[c] + stepVec[c]); // R8 R26
               end
            end else if (xferDone[c]) begin
               xferIdx[c] <= '0; // R20
               case (opMode)
                  dma_channel_pkg::OPMODE_CONT: begin
                     ramPtr[c] <= primaryStart[c]; // R11 R24
                  end
                  dma_channel_pkg::OPMODE_ONESHOT: begin
                     control[c][dma_channel_pkg::CTRL_ENABLE_BIT] <= 1'b0; // R11 R23 R27
                  end
                  dma_channel_pkg::OPMODE_CONT_PP: begin
                     pingSel[c] <= ~pingSel[c]; // R10 R25
                     ramPtr[c]  <= pingSel[c] ? primaryStart[c] : secondaryStart[c]; // R24
                  end
                  dma_channel_pkg::OPMODE_ONESHOT_PP: begin
                     if (!pingSel[c]) begin
                        pingSel[c] <= 1'b1; // R9 R25
                        ramPtr[c]  <= secondaryStart[c];
                     end else begin
                        pingSel[c] <= 1'b0;
                        control[c][dma_channel_pkg::CTRL_ENABLE_BIT] <= 1'b0; // R9 R23 R27
                     end
                  end
                  default: begin
                     ramPtr[c] <= primaryStart[c];
                  end
               endcase
            end
         end
      end
   end

   // ===========================================================
   // Transfer engine: read, capture, write; one transfer every four cycles.
   // Peripheral address and count are sampled live, so a change while
   // enabled lands mid-block.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state       <= dma_channel_pkg::ENG_IDLE;
         curCh       <= '0;
         curForced   <= 1'b0;
         curDir      <= 1'b0;
         curNull     <= 1'b0;
         ramAddr     <= 16'h0000;
         ramRead     <= 1'b0;
         ramWrite    <= 1'b0;
         ramByte     <= 1'b0;
         ramWdata    <= 16'h0000;
         periphAddr  <= 16'h0000;
         periphRead  <= 1'b0;
         periphWrite <= 1'b0;
         periphWdata <= 16'h0000;
      end else begin
         case (state)
            dma_channel_pkg::ENG_IDLE: begin
               if (anyEligible) begin
                  curCh      <= grantCh;
                  curForced  <= forceReq[grantCh]; // R12
                  curDir     <= grantCtl[dma_channel_pkg::CTRL_DIR_BIT];
                  // Null write is honoured only in peripheral-to-RAM direction
                  curNull    <= grantCtl[dma_channel_pkg::CTRL_NULL_PERIPHERAL_WRITE_BIT]
                                & ~grantCtl[dma_channel_pkg::CTRL_DIR_BIT]; // R6
                  ramByte    <= grantCtl[dma_channel_pkg::CTRL_SIZE_BIT]; // R3
                  ramAddr    <= grantRam; // R8
                  periphAddr <= periphTarget[grantCh]; // R18 R19
                  ramRead    <= grantCtl[dma_channel_pkg::CTRL_DIR_BIT]; // R4
                  periphRead <= ~grantCtl[dma_channel_pkg::CTRL_DIR_BIT]; // R4
                  state      <= dma_channel_pkg::ENG_READ;
               end
            end
            dma_channel_pkg::ENG_READ: begin
               ramRead    <= 1'b0;
               periphRead <= 1'b0;
               state      <= dma_channel_pkg::ENG_CAPTURE;
            end
            dma_channel_pkg::ENG_CAPTURE: begin
               ramWrite    <= ~curDir; // R4
               periphWrite <= curDir | curNull; // R6
               ramWdata    <= periphRdata;
               periphWdata <= curDir ? ramRdata : 16'h0000; // R6
               state       <= dma_channel_pkg::ENG_WRITE;
            end
            dma_channel_pkg::ENG_WRITE: begin
               ramWrite    <= 1'b0;
               periphWrite <= 1'b0;
               state       <= dma_channel_pkg::ENG_IDLE;
            end
            default: begin
               state <= dma_channel_pkg::ENG_IDLE;
            end
         endcase
      end
   end

   // ===========================================================
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   wire [1:0] amode0 = control[0][dma_channel_pkg::CTRL_ADDRESSING_MODE_LSB +: 2];
   wire [1:0] mode0  = control[0][dma_channel_pkg::CTRL_MODE_LSB +: 2];

   chk_idle_needs_enable: assert property ( // R2
      (state == dma_channel_pkg::ENG_IDLE && (enableVec & (pending | forceReq)) == '0)
      |=> state == dma_channel_pkg::ENG_IDLE)
      else $error("engine left idle with no enabled requester");
   chk_size_follows: assert property ( // R3
      grantNow |=> ramByte == $past(grantCtl[dma_channel_pkg::CTRL_SIZE_BIT]))
      else $error("byte flag differs from size bit at grant");
   chk_dir_ram_source: assert property ( // R4
      (grantNow && grantCtl[dma_channel_pkg::CTRL_DIR_BIT])
      |=> ramRead && !periphRead ##2 periphWrite && !ramWrite)
      else $error("RAM-to-peripheral sequence wrong");
   chk_dir_periph_source: assert property ( // R4
      (grantNow && !grantCtl[dma_channel_pkg::CTRL_DIR_BIT])
      |=> periphRead && !ramRead ##2 ramWrite)
      else $error("peripheral-to-RAM sequence wrong");
   chk_null_write_zero: assert property ( // R6
      (ramWrite && curNull) |-> periphWrite && periphWdata == 16'h0000)
      else $error("null write missing or nonzero");
   chk_force_self_clear: assert property ( // R13
      (xferDone[0] && curForced && !forceSet[0])
      |=> !requestSel[0][dma_channel_pkg::REQ_FORCE_BIT])
      else $error("force bit not cleared after forced transfer");
   chk_fixed_addr_hold: assert property ( // R8
      (xferDone[0] && !lastBlk[0] && enableVec[0] && amode0 == dma_channel_pkg::ADDRESSING_MODE_FIXED)
      |=> ramPtr[0] == $past(ramPtr[0]))
      else $error("fixed-address mode moved the pointer");
   chk_postinc_step: assert property ( // R26
      (xferDone[0] && !lastBlk[0] && enableVec[0] && amode0 == dma_channel_pkg::ADDRESSING_MODE_POSTINC)
      |=> ramPtr[0] == $past(ramPtr[0]) + $past(stepVec[0]))
      else $error("post-increment step wrong");
   chk_oneshot_stops: assert property ( // R23
      (xferDone[0] && lastBlk[0] && enableVec[0] && mode0 == dma_channel_pkg::OPMODE_ONESHOT)
      |=> !enableVec[0])
      else $error("one-shot channel still enabled after block");
   chk_irq_cause: assert property ( // R22
      blockIrq[0] |-> $past(xferDone[0]))
      else $error("interrupt without a completed transfer");
   chk_block_wrap: assert property ( // R20
      (xferDone[0] && lastBlk[0]) |=> xferIdx[0] == 10'h000)
      else $error("transfer index did not wrap at block end");

   cov_forced_done:  cover property (xferDone[0] && curForced);
   cov_pingpong_sw:  cover property (xferDone[0] && lastBlk[0]
                                     && mode0 == dma_channel_pkg::OPMODE_CONT_PP);
   cov_half_irq:     cover property (blockIrq[0] && control[0][dma_channel_pkg::CTRL_HALF_BIT]);
   cov_null_write:   cover property (ramWrite && curNull);

endmodule : dma_channel_register_control

`default_nettype wire
